//--- mom_pkg.sv
// How it works
// [RULE_01] estimate is 100% times (avg/rated current) squared times (1 - exp(-t/T))
// [RULE_02] rated current is the lower of motor and amplifier continuous ratings
// [RULE_03] software loads rated current, overload factor and time constant first
// [RULE_04] estimate stays at zero until software sets the enable bit
// [RULE_05] programmable warning level flags once the estimate reaches it
// [RULE_06] estimate reaching fixed 100% raises error code 30
// [RULE_07] estimate readable at any time over the register bus
// [RULE_08] after reset the estimate starts from zero
// [RULE_09] reset defaults: 3 A rated, overload factor 2, time constant 1800 s
// [RULE_10] trip current is 1.15 times the user-set rated current
// [RULE_11] average current at trip level switches motor off in bounded time
// [RULE_12] twice trip current switches off after no less than 8 minutes
// [RULE_13] six times trip current switches off after no less than 20 seconds
// [RULE_14] overload trip raises error code 31, only rated current configures it
// [RULE_15] overload trip is always active and cannot be disabled
// [RULE_16] averaging and estimate update at fixed clock-derived rates, fixed point
// [RULE_17] either error latches and disables the output stage until cleared
package mom_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_MOT_RATED = 8'h04;
   localparam logic [7:0] OFF_OVL_FAC = 8'h08;
   localparam logic [7:0] OFF_TAU = 8'h0C;
   localparam logic [7:0] OFF_WARN = 8'h10;
   localparam logic [7:0] OFF_PCT = 8'h14;
   localparam logic [7:0] OFF_STAT = 8'h18;
   localparam logic [7:0] OFF_MASK = 8'h1C;
   localparam logic [7:0] OFF_ERR = 8'h20;
   localparam logic [7:0] OFF_IAVG = 8'h24;
   localparam logic [15:0] RST_RATED_MA = 16'h0BB8;
   localparam logic [7:0] RST_OVL_FAC = 8'h02;
   localparam logic [15:0] RST_TAU_S = 16'h0708;
   localparam logic [7:0] RST_WARN_PCT = 8'h50;
   localparam int ST_WARN = 0;
   localparam int ST_E30 = 1;
   localparam int ST_E31 = 2;
   localparam logic [7:0] ERR_I2T = 8'h1E;
   localparam logic [7:0] ERR_OVL = 8'h1F;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [47:0] PH_STEP = 48'h0000_0001_0000;
   localparam int PH_SHIFT = 16;
   localparam int PCT_FULL = 100;
   localparam int OL_TRIP_PCT = 115;
   localparam int OL_MIN_2X_S = 480;
   localparam int OL_RATIO_2X = 4;
   localparam int OL_FULL_S = OL_MIN_2X_S * OL_RATIO_2X;
   localparam int OL_TICK_MS = 100;
   localparam int OL_TICK_CYC = OL_TICK_MS * (CLK_HZ / 1000);
   localparam int OL_K_TICKS = OL_FULL_S * 1000 / OL_TICK_MS;
   localparam logic [63:0] OL_LIM_K = 64'(OL_TRIP_PCT * OL_TRIP_PCT) * 64'(OL_K_TICKS);
   localparam logic [63:0] OL_PCT_SQ = 64'(PCT_FULL * PCT_FULL);
   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } mom_axi_req_t;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } mom_axi_rsp_t;
endpackage

//--- mom_monitor.sv
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
module mom_monitor #(
   parameter int CLK_HZ = mom_pkg::CLK_HZ,
   parameter logic [15:0] AMP_RATED_MA = 16'h0BB8,
   parameter int AVG_SHIFT = 10,
   parameter int OL_TICK_CYC = mom_pkg::OL_TICK_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire mom_pkg::mom_axi_req_t axi_req,
   output mom_pkg::mom_axi_rsp_t axi_rsp,
   input wire logic [15:0] i_motor_ma,
   output logic [23:0] i_peak_limit,
   output logic stage_off,
   output logic irq
);
   localparam int AW = 16 + AVG_SHIFT;

   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic arready_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic ctrl_en_r;
   logic [15:0] mot_rated_r;
   logic [7:0] ovl_fac_r;
   logic [15:0] tau_r;
   logic [7:0] warn_r;
   logic [2:0] mask_r;
   logic [2:0] stat_r;
   logic [7:0] err_r;
   logic [AW-1:0] avg_acc_r;
   logic [47:0] ph_r;
   logic [47:0] y_r;
   logic [38:0] num_r;
   logic [15:0] q_r;
   logic [3:0] idx_r;
   logic [15:0] pct_r;
   logic [31:0] ol_cnt_r;
   logic [47:0] z_r;
   logic [23:0] ipk_r;
   logic stage_off_r;
   logic irq_r;

   assign axi_rsp = '{awready: awready_r, wready: wready_r, bvalid: bvalid_r,
                      bresp: bresp_r, arready: arready_r, rvalid: rvalid_r,
                      rdata: rdata_r, rresp: rresp_r};
   assign i_peak_limit = ipk_r;
   assign stage_off = stage_off_r;
   assign irq = irq_r;

   // bus decode
   wire aw_hs = axi_req.awvalid & awready_r;
   wire w_hs = axi_req.wvalid & wready_r;
   wire b_hs = bvalid_r & axi_req.bready;
   wire ar_hs = axi_req.arvalid & arready_r;
   wire r_hs = rvalid_r & axi_req.rready;
   wire do_wr = ~awready_r & ~wready_r & ~bvalid_r;
   wire [31:0] wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
   wire wr_ctrl = do_wr & (aw_addr_r == mom_pkg::OFF_CTRL);
   wire wr_rated = do_wr & (aw_addr_r == mom_pkg::OFF_MOT_RATED);
   wire wr_fac = do_wr & (aw_addr_r == mom_pkg::OFF_OVL_FAC);
   wire wr_tau = do_wr & (aw_addr_r == mom_pkg::OFF_TAU);
   wire wr_warn = do_wr & (aw_addr_r == mom_pkg::OFF_WARN);
   wire wr_stat = do_wr & (aw_addr_r == mom_pkg::OFF_STAT);
   wire wr_mask = do_wr & (aw_addr_r == mom_pkg::OFF_MASK);
   wire ro_hit = (aw_addr_r == mom_pkg::OFF_PCT) | (aw_addr_r == mom_pkg::OFF_ERR) |
                 (aw_addr_r == mom_pkg::OFF_IAVG);
   wire wr_ok = wr_ctrl | wr_rated | wr_fac | wr_tau | wr_warn | wr_stat | wr_mask | ro_hit;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [31:0] m);
      merge = (old & ~m) | (nw & m);
   endfunction

   wire [31:0] m_ctrl = merge({31'h0, ctrl_en_r}, w_data_r, wmask);
   wire [31:0] m_rated = merge({16'h0, mot_rated_r}, w_data_r, wmask);
   wire [31:0] m_fac = merge({24'h0, ovl_fac_r}, w_data_r, wmask);
   wire [31:0] m_tau = merge({16'h0, tau_r}, w_data_r, wmask);
   wire [31:0] m_warn = merge({24'h0, warn_r}, w_data_r, wmask);
   wire [31:0] m_mask = merge({29'h0, mask_r}, w_data_r, wmask);
   wire [2:0] stat_clr = wr_stat ? (w_data_r[2:0] & wmask[2:0]) : 3'h0;

   // model arithmetic
   wire [15:0] irs = (mot_rated_r < AMP_RATED_MA) ? mot_rated_r : AMP_RATED_MA; // RULE_02
   wire [31:0] irs2 = 32'(irs) * 32'(irs);
   wire [15:0] iavg = avg_acc_r[AW-1:AVG_SHIFT];
   wire [31:0] iavg2 = 32'(iavg) * 32'(iavg);
   wire [AW-1:0] avg_nxt = avg_acc_r + AW'(i_motor_ma) - AW'(iavg); // RULE_16
   wire [47:0] tau_cyc = 48'(tau_r) * 48'(CLK_HZ);
   wire [47:0] ph_sum = ph_r + mom_pkg::PH_STEP;
   wire i2t_tick = ph_sum >= tau_cyc; // RULE_16
   wire [47:0] ph_nxt = i2t_tick ? ph_sum - tau_cyc : ph_sum;
   // first-order step of 2^-16 every T/2^16 s gives time constant T
   wire signed [48:0] y_diff = $signed({1'b0, iavg2, 16'h0}) - $signed({1'b0, y_r});
   wire signed [48:0] y_step = y_diff >>> mom_pkg::PH_SHIFT;
   wire [47:0] y_nxt = y_r + y_step[47:0]; // RULE_01
   wire [31:0] y_int = y_r[47:16];
   wire [38:0] y_pct = 39'(y_int) * 39'(mom_pkg::PCT_FULL);
   wire warn_hit = ctrl_en_r & (y_pct >= 39'(warn_r) * 39'(irs2)); // RULE_05
   wire e30_hit = ctrl_en_r & (y_int >= irs2); // RULE_06

   // percent readout by successive approximation
   wire [15:0] trial = q_r | (16'h0001 << idx_r);
   wire keep = (48'(trial) * 48'(irs2)) <= 48'(num_r);
   wire [15:0] q_nxt = keep ? trial : q_r;

   // overload trip, only the user-set rated current enters
   wire [31:0] m2 = 32'(mot_rated_r) * 32'(mot_rated_r);
   wire ol_over = (32'(iavg) * 32'(mom_pkg::PCT_FULL)) >= (32'(mot_rated_r) * 32'(mom_pkg::OL_TRIP_PCT)); // RULE_10
   wire ol_tick = ol_cnt_r == 32'(OL_TICK_CYC - 1);
   // time to trip at full trip current stays bounded, 1/4 of it at 2x, 1/36 at 6x
   wire ol_trip = (64'(z_r) * mom_pkg::OL_PCT_SQ) >= (64'(m2) * mom_pkg::OL_LIM_K); // RULE_11 RULE_12 RULE_13
   wire [47:0] z_cool = (z_r > 48'(m2)) ? z_r - 48'(m2) : 48'h0;
   wire [47:0] z_nxt = ol_over ? (ol_trip ? z_r : z_r + 48'(iavg2)) : z_cool;

   // status, set wins over clear
   wire [2:0] stat_set = {ol_trip, e30_hit, warn_hit}; // RULE_15
   wire [2:0] stat_nxt = (stat_r & ~stat_clr) | stat_set; // RULE_17

   logic [31:0] rd_val;
   logic rd_ok;
   always_comb begin
      rd_ok = 1'b1;
      case (axi_req.araddr)
         mom_pkg::OFF_CTRL: rd_val = {31'h0, ctrl_en_r};
         mom_pkg::OFF_MOT_RATED: rd_val = {16'h0, mot_rated_r};
         mom_pkg::OFF_OVL_FAC: rd_val = {24'h0, ovl_fac_r};
         mom_pkg::OFF_TAU: rd_val = {16'h0, tau_r};
         mom_pkg::OFF_WARN: rd_val = {24'h0, warn_r};
         mom_pkg::OFF_PCT: rd_val = {16'h0, pct_r}; // RULE_07
         mom_pkg::OFF_STAT: rd_val = {29'h0, stat_r};
         mom_pkg::OFF_MASK: rd_val = {29'h0, mask_r};
         mom_pkg::OFF_ERR: rd_val = {24'h0, err_r};
         mom_pkg::OFF_IAVG: rd_val = {16'h0, iavg};
         default: begin
            rd_val = 32'h0;
            rd_ok = 1'b0;
         end
      endcase
   end

   // write channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r <= mom_pkg::RESP_OKAY;
      end else begin
         if (aw_hs) awready_r <= 1'b0;
         if (w_hs) wready_r <= 1'b0;
         if (do_wr) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_ok ? mom_pkg::RESP_OKAY : mom_pkg::RESP_SLVERR;
         end
         if (b_hs) begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
      end else begin
         if (aw_hs) aw_addr_r <= axi_req.awaddr;
         if (w_hs) begin
            w_data_r <= axi_req.wdata;
            w_strb_r <= axi_req.wstrb;
         end
      end
   end

   // read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0;
         rresp_r <= mom_pkg::RESP_OKAY;
      end else if (ar_hs) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= rd_val;
         rresp_r <= rd_ok ? mom_pkg::RESP_OKAY : mom_pkg::RESP_SLVERR;
      end else if (r_hs) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
      end
   end

   // parameter registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_en_r <= 1'b0;
         mot_rated_r <= mom_pkg::RST_RATED_MA; // RULE_09
         ovl_fac_r <= mom_pkg::RST_OVL_FAC; // RULE_09
         tau_r <= mom_pkg::RST_TAU_S; // RULE_09
         warn_r <= mom_pkg::RST_WARN_PCT;
         mask_r <= 3'h0;
      end else begin
         if (wr_ctrl) ctrl_en_r <= m_ctrl[0]; // RULE_04
         if (wr_rated) mot_rated_r <= m_rated[15:0];
         if (wr_fac) ovl_fac_r <= m_fac[7:0];
         if (wr_tau) tau_r <= m_tau[15:0];
         if (wr_warn) warn_r <= m_warn[7:0];
         if (wr_mask) mask_r <= m_mask[2:0];
      end
   end

   // current average, every clock
   always_ff @(posedge aclk) begin
      if (!aresetn) avg_acc_r <= '0;
      else avg_acc_r <= avg_nxt;
   end

   // thermal model; disabled means held at zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ph_r <= 48'h0;
         y_r <= 48'h0; // RULE_08
      end else if (!ctrl_en_r) begin
         ph_r <= 48'h0;
         y_r <= 48'h0; // RULE_04
      end else begin
         ph_r <= ph_nxt;
         if (i2t_tick) y_r <= y_nxt; // RULE_01
      end
   end

   // readout may lag the model by up to 32 clocks
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         num_r <= 39'h0;
         q_r <= 16'h0;
         idx_r <= 4'hF;
         pct_r <= 16'h0;
      end else if (idx_r == 4'h0) begin
         pct_r <= q_nxt; // RULE_07
         num_r <= y_pct;
         q_r <= 16'h0;
         idx_r <= 4'hF;
      end else begin
         q_r <= q_nxt;
         idx_r <= idx_r - 4'h1;
      end
   end

   // overload trip integrator, never gated
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ol_cnt_r <= 32'h0;
         z_r <= 48'h0;
      end else begin
         ol_cnt_r <= ol_tick ? 32'h0 : ol_cnt_r + 32'h1;
         if (ol_tick) z_r <= z_nxt; // RULE_15
      end
   end

   // errors, interrupt, output stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_r <= 3'h0;
         err_r <= 8'h00;
         irq_r <= 1'b0;
         stage_off_r <= 1'b0;
         ipk_r <= 24'h0;
      end else begin
         stat_r <= stat_nxt;
         if (ol_trip & ~stat_r[mom_pkg::ST_E31]) err_r <= mom_pkg::ERR_OVL; // RULE_14
         else if (e30_hit & ~stat_r[mom_pkg::ST_E30]) err_r <= mom_pkg::ERR_I2T; // RULE_06
         irq_r <= |(stat_nxt & mask_r);
         stage_off_r <= stat_nxt[mom_pkg::ST_E30] | stat_nxt[mom_pkg::ST_E31]; // RULE_17
         ipk_r <= 24'(irs) * 24'(ovl_fac_r);
      end
   end
endmodule

//--- mom_monitor_properties.sv
`timescale 1ns/100ps
module mom_monitor_properties (
   input wire logic aclk,
   input wire logic aresetn,
   input wire mom_pkg::mom_axi_req_t axi_req,
   input wire mom_pkg::mom_axi_rsp_t axi_rsp,
   input wire logic [15:0] i_motor_ma,
   input wire logic [23:0] i_peak_limit,
   input wire logic stage_off,
   input wire logic irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_wr_resp;
      axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready |=> !axi_rsp.awready ##1 axi_rsp.bvalid;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write response late");
   property p_b_hold;
      axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_rd_resp;
      axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready;
   endproperty
   a_rd_resp: assert property (p_rd_resp) else $error("read response late");
   property p_r_hold;
      axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data unstable");
   property p_rd_err;
      axi_req.arvalid && axi_rsp.arready && axi_req.araddr > 8'h24 |=>
         axi_rsp.rresp == mom_pkg::RESP_SLVERR && axi_rsp.rdata == 32'h0000_0000;
   endproperty
   a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
   property p_rst_quiet;
      !$past(aresetn) |-> !stage_off && !irq;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
   property p_peak_dflt;
      aresetn && !$past(aresetn) |=> i_peak_limit == 24'h001770;
   endproperty
   a_peak_dflt: assert property (p_peak_dflt) else $error("peak limit default wrong");
   // only a status write may release the stage, never a quiet condition
   property p_stage_clr;
      $fell(stage_off) |-> axi_rsp.bvalid || $past(axi_rsp.bvalid);
   endproperty
   a_stage_clr: assert property (p_stage_clr) else $error("stage released without clear");
endmodule

//--- mom_plc_model.sv
`timescale 1ns/100ps
module mom_plc_model (
   input wire logic aclk,
   output mom_pkg::mom_axi_req_t axi_req,
   input wire mom_pkg::mom_axi_rsp_t axi_rsp
);
   initial axi_req = '0;
   // bready and rready go up with the request, answer taken at the edge it is seen
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ad;
      logic wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      axi_req.awvalid <= 1'b1;
      axi_req.awaddr <= a;
      axi_req.wvalid <= 1'b1;
      axi_req.wdata <= d;
      axi_req.wstrb <= 4'hF;
      axi_req.bready <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (axi_rsp.awready && !ad) begin
            ad = 1'b1;
            axi_req.awvalid <= 1'b0;
            axi_req.awaddr <= ~a;
         end
         if (axi_rsp.wready && !wd) begin
            wd = 1'b1;
            axi_req.wvalid <= 1'b0;
            axi_req.wdata <= ~d;
         end
      end
      do @(posedge aclk); while (!axi_rsp.bvalid);
      r = axi_rsp.bresp;
      axi_req.bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      axi_req.arvalid <= 1'b1;
      axi_req.araddr <= a;
      axi_req.rready <= 1'b1;
      do @(posedge aclk); while (!axi_rsp.arready);
      axi_req.arvalid <= 1'b0;
      axi_req.araddr <= ~a;
      do @(posedge aclk); while (!axi_rsp.rvalid);
      d = axi_rsp.rdata;
      r = axi_rsp.rresp;
      axi_req.rready <= 1'b0;
   endtask
endmodule

//--- mom_monitor_tb_top.sv
`timescale 1ns/100ps
module mom_monitor_tb_top;
   logic aclk;
   logic aresetn;
   mom_pkg::mom_axi_req_t axi_req;
   mom_pkg::mom_axi_rsp_t axi_rsp;
   logic [15:0] i_motor_ma;
   logic [23:0] i_peak_limit;
   logic stage_off;
   logic irq;
   int error_cnt = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [31:0] rd_v;
   logic [1:0] rs_v;
   localparam logic [7:0] OFF_TBL [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
   localparam logic [31:0] RST_TBL [9] = '{32'h0, 32'h0BB8, 32'h2, 32'h0708, 32'h50, 32'h0, 32'h0, 32'h0, 32'h0};
   // one tau tick per clock and 10-clock overload ticks keep the run short
   mom_monitor #(.CLK_HZ(65536), .AVG_SHIFT(2), .OL_TICK_CYC(10)) u_mom_monitor (.aclk(aclk), .aresetn(aresetn),
      .axi_req(axi_req), .axi_rsp(axi_rsp), .i_motor_ma(i_motor_ma), .i_peak_limit(i_peak_limit),
      .stage_off(stage_off), .irq(irq));
   mom_plc_model u_plc (.aclk(aclk), .axi_req(axi_req), .axi_rsp(axi_rsp));
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         error_cnt++;
         conclude();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rg(input logic [7:0] a, input logic [31:0] e);
      u_plc.rd(a, rd_v, rs_v);
      chk(rd_v, e);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_plc.wr(a, d, rs_v);
      // outputs fed by the new register value settle one edge after the response
      @(posedge aclk);
   endtask
   task automatic do_reset;
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
   endtask
   task automatic t_reset;
      for (int k = 0; k < 9; k++) rg(OFF_TBL[k], RST_TBL[k]);
      chk(32'(i_peak_limit), 32'h1770);
      $display("test reset values done");
   endtask
   task automatic t_bus;
      wr(8'h40, 32'h1);
      chk(32'(rs_v), 32'h2);
      u_plc.rd(8'h40, rd_v, rs_v);
      chk(rd_v, 32'h0);
      chk(32'(rs_v), 32'h2);
      wr(8'h14, 32'hFF);
      chk(32'(rs_v), 32'h0);
      rg(8'h14, 32'h0);
      $display("test bus refusals done");
   endtask
   task automatic t_rated;
      wr(8'h04, 32'h0FA0);
      chk(32'(i_peak_limit), 32'h1770);
      wr(8'h04, 32'h07D0);
      chk(32'(i_peak_limit), 32'h0FA0);
      wr(8'h08, 32'h3);
      chk(32'(i_peak_limit), 32'h1770);
      wr(8'h04, 32'h0BB8);
      wr(8'h08, 32'h2);
      $display("test rated current done");
   endtask
   task automatic t_i2t;
      wr(8'h0C, 32'h1);
      wr(8'h1C, 32'h7);
      i_motor_ma <= 16'h1770;
      repeat (2000) @(posedge aclk);
      rg(8'h14, 32'h0);
      wr(8'h00, 32'h1);
      repeat (12000) @(posedge aclk);
      u_plc.rd(8'h14, rd_v, rs_v);
      chk(32'(rd_v >= 32'd60 && rd_v <= 32'd72), 32'h1);
      rg(8'h18, 32'h0);
      for (int k = 0; k < 4000 && !irq; k++) @(posedge aclk);
      chk(32'(irq), 32'h1);
      rg(8'h18, 32'h1);
      wr(8'h1C, 32'h0);
      chk(32'(irq), 32'h0);
      wr(8'h1C, 32'h7);
      for (int k = 0; k < 6000 && !stage_off; k++) @(posedge aclk);
      chk(32'(stage_off), 32'h1);
      rg(8'h20, 32'h1E);
      i_motor_ma <= 16'h0;
      wr(8'h00, 32'h0);
      repeat (50) @(posedge aclk);
      chk(32'(stage_off), 32'h1);
      wr(8'h18, 32'h7);
      rg(8'h18, 32'h0);
      chk(32'(stage_off), 32'h0);
      $display("test thermal estimate done");
   endtask
   task automatic t_ovl;
      do_reset();
      i_motor_ma <= 16'h1AF4;
      repeat (47000) @(posedge aclk);
      chk(32'(stage_off), 32'h0);
      for (int k = 0; k < 2000 && !stage_off; k++) @(posedge aclk);
      chk(32'(stage_off), 32'h1);
      rg(8'h20, 32'h1F);
      rg(8'h18, 32'h4);
      $display("test overload trip done");
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      aresetn = 1'b0;
      i_motor_ma = 16'h0;
      do_reset();
      t_reset();
      t_bus();
      t_rated();
      t_i2t();
      t_ovl();
      conclude();
   end
endmodule
bind mom_monitor mom_monitor_properties u_mom_monitor_properties (.aclk(aclk), .aresetn(aresetn),
   .axi_req(axi_req), .axi_rsp(axi_rsp), .i_motor_ma(i_motor_ma), .i_peak_limit(i_peak_limit),
   .stage_off(stage_off), .irq(irq));
